//--- src/dpu_top.sv
// Dual data pointer unit: control register, pointer banking and auto update.

module dpu_top
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Special register bus from the core.
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_hit_o,
	// Instruction operations on the active pointer.
	input wire logic ptr_load_i,
	input wire logic [dpu_pkg::PTR_W-1:0] ptr_load_val_i,
	input wire logic ptr_inc_i,
	input wire logic move_done_i,
	input wire dpu_pkg::dpu_addr_t move_addr_i,
	// Pointer state seen by the core.
	output logic [dpu_pkg::PTR_W-1:0] active_pointer_o,
	output logic pointer_select_o
);

	// Control register fields.
	logic pointer_select_r;
	logic auto_toggle_enable_r;
	dpu_pkg::dpu_mode_t shadow_mode_r;
	dpu_pkg::dpu_mode_t main_mode_r;

	// Output and read-back flops.
	logic [dpu_pkg::PTR_W-1:0] active_pointer_r;
	logic [dpu_pkg::PTR_W-1:0] active_pointer_nxt;
	logic [7:0] sfr_rdata_r;
	logic [7:0] sfr_rdata_nxt;
	logic sfr_hit_r;

	// Pointer storage and steps.
	logic [dpu_pkg::PTR_W-1:0] main_ptr;
	logic [dpu_pkg::PTR_W-1:0] shadow_ptr;
	logic [dpu_pkg::PTR_W-1:0] main_step;
	logic [dpu_pkg::PTR_W-1:0] shadow_step;
	logic [dpu_pkg::PTR_W-1:0] main_ptr_nxt;
	logic [dpu_pkg::PTR_W-1:0] shadow_ptr_nxt;

	// Decoded requests.
	// All of these are combinational; all but ctrl_value live for one cycle only.
	dpu_pkg::dpu_byte_t wr_byte;
	dpu_pkg::dpu_byte_t rd_byte;
	logic ctrl_wr;
	logic byte_wr;
	logic qual_move;
	logic [7:0] ctrl_value;

	// Maps a bus address onto one of the three pointer bytes.
	// An unmapped address yields the none code, which every consumer treats as no access.
	function automatic dpu_pkg::dpu_byte_t decode_byte(input logic [7:0] addr);
		dpu_pkg::dpu_byte_t b;
		b = dpu_pkg::DPU_BYTE_NONE;
		if (addr == dpu_pkg::PTR_LOW_ADDR)
			b = dpu_pkg::DPU_BYTE_LOW;
		else if (addr == dpu_pkg::PTR_HIGH_ADDR)
			b = dpu_pkg::DPU_BYTE_HIGH;
		else if (addr == dpu_pkg::PTR_PAGE_ADDR)
			b = dpu_pkg::DPU_BYTE_PAGE;
		return b;
	endfunction

	// Picks one byte out of a pointer; a non-pointer address reads zero.
	function automatic logic [7:0] pick_byte(input logic [dpu_pkg::PTR_W-1:0] ptr, input dpu_pkg::dpu_byte_t b);
		logic [7:0] v;
		v = dpu_pkg::READ_ZERO;
		unique case (b)
			dpu_pkg::DPU_BYTE_LOW: v = ptr[dpu_pkg::LOW_LSB +: dpu_pkg::BYTE_W];
			dpu_pkg::DPU_BYTE_HIGH: v = ptr[dpu_pkg::HIGH_LSB +: dpu_pkg::BYTE_W];
			dpu_pkg::DPU_BYTE_PAGE: v = ptr[dpu_pkg::PAGE_LSB +: dpu_pkg::BYTE_W];
			dpu_pkg::DPU_BYTE_NONE: v = dpu_pkg::READ_ZERO;
		endcase
		return v;
	endfunction

	// Bus and move decode.
	// Reads and writes share one decoder, since the bus carries one address per cycle.
	assign wr_byte = decode_byte(sfr_addr_i);
	assign rd_byte = wr_byte;
	assign ctrl_wr = sfr_wr_i && (sfr_addr_i == dpu_pkg::CTRL_ADDR);
	assign byte_wr = sfr_wr_i && (wr_byte != dpu_pkg::DPU_BYTE_NONE);
	// Program-counter and register-indirect moves never touch the pointers.
	assign qual_move = move_done_i && (move_addr_i == dpu_pkg::DPU_ADDR_PTR);

	// Control register image; bits seven and one are not stored and read as zero.
	// Leaving bit one unstored is what lets an increment of the whole register flip the select alone.
	always_comb
	begin
		ctrl_value = dpu_pkg::READ_ZERO;
		ctrl_value[dpu_pkg::SEL_BIT] = pointer_select_r;
		ctrl_value[dpu_pkg::MAIN_MODE_LSB +: 2] = main_mode_r;
		ctrl_value[dpu_pkg::SHADOW_MODE_LSB +: 2] = shadow_mode_r;
		ctrl_value[dpu_pkg::TOGGLE_BIT] = auto_toggle_enable_r;
	end

	// Each pointer steps by its own mode field.
	// The step modules are purely combinational; stored values change only in the pointer registers.
	dpu_ptr_step u_main_step
	(
		.ptr_i(main_ptr),
		.mode_i(main_mode_r),
		.step_o(main_step)
	);

	dpu_ptr_step u_shadow_step
	(
		.ptr_i(shadow_ptr),
		.mode_i(shadow_mode_r),
		.step_o(shadow_step)
	);

	// The main pointer takes every operation only while it is selected.
	// Gating every enable with the select keeps the inactive pointer frozen, whatever the core does.
	dpu_ptr_reg u_main_ptr
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.wr_en_i(byte_wr && !pointer_select_r),
		.wr_byte_i(wr_byte),
		.wr_data_i(sfr_wdata_i),
		.load_en_i(ptr_load_i && !pointer_select_r),
		.load_val_i(ptr_load_val_i),
		.inc_en_i(ptr_inc_i && !pointer_select_r),
		.step_en_i(qual_move && !pointer_select_r),
		.step_val_i(main_step),
		.ptr_o(main_ptr)
	);

	// The shadow pointer takes every operation only while it is selected.
	dpu_ptr_reg u_shadow_ptr
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.wr_en_i(byte_wr && pointer_select_r),
		.wr_byte_i(wr_byte),
		.wr_data_i(sfr_wdata_i),
		.load_en_i(ptr_load_i && pointer_select_r),
		.load_val_i(ptr_load_val_i),
		.inc_en_i(ptr_inc_i && pointer_select_r),
		.step_en_i(qual_move && pointer_select_r),
		.step_val_i(shadow_step),
		.ptr_o(shadow_ptr)
	);

	// Select bit: a bus write wins over an automatic swap in the same cycle.
	// Letting the write win means software can always force a known pointer, even inside a loop.
	// The swap uses the old select, so the pointer that did the move is the one stepped first.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			pointer_select_r <= dpu_pkg::CTRL_RESET[dpu_pkg::SEL_BIT];
		else if (ctrl_wr)
			pointer_select_r <= sfr_wdata_i[dpu_pkg::SEL_BIT];
		else if (qual_move && auto_toggle_enable_r)
			pointer_select_r <= !pointer_select_r;
	end

	// Mode fields and toggle enable change only by bus writes.
	// They never step by themselves, so a copy of them taken on the bus side stays exact.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			auto_toggle_enable_r <= dpu_pkg::CTRL_RESET[dpu_pkg::TOGGLE_BIT];
			shadow_mode_r <= dpu_pkg::dpu_mode_t'(dpu_pkg::CTRL_RESET[dpu_pkg::SHADOW_MODE_LSB +: 2]);
			main_mode_r <= dpu_pkg::dpu_mode_t'(dpu_pkg::CTRL_RESET[dpu_pkg::MAIN_MODE_LSB +: 2]);
		end
		else if (ctrl_wr)
		begin
			auto_toggle_enable_r <= sfr_wdata_i[dpu_pkg::TOGGLE_BIT];
			shadow_mode_r <= dpu_pkg::dpu_mode_t'(sfr_wdata_i[dpu_pkg::SHADOW_MODE_LSB +: 2]);
			main_mode_r <= dpu_pkg::dpu_mode_t'(sfr_wdata_i[dpu_pkg::MAIN_MODE_LSB +: 2]);
		end
	end

	// Next pointer values mirror the priority inside the pointer registers.
	// Any change to the priority in the pointer module must be made here too, or the
	// registered active pointer will drift one cycle away from the stored one.
	always_comb
	begin
		main_ptr_nxt = main_ptr;
		shadow_ptr_nxt = shadow_ptr;
		if (!pointer_select_r)
		begin
			if (byte_wr)
				main_ptr_nxt = main_ptr;
			else if (ptr_load_i)
				main_ptr_nxt = ptr_load_val_i;
			else if (ptr_inc_i)
				main_ptr_nxt = main_ptr + dpu_pkg::PTR_ONE;
			else if (qual_move)
				main_ptr_nxt = main_step;
			if (byte_wr)
			begin
				unique case (wr_byte)
					dpu_pkg::DPU_BYTE_LOW: main_ptr_nxt[dpu_pkg::LOW_LSB +: dpu_pkg::BYTE_W] = sfr_wdata_i;
					dpu_pkg::DPU_BYTE_HIGH: main_ptr_nxt[dpu_pkg::HIGH_LSB +: dpu_pkg::BYTE_W] = sfr_wdata_i;
					dpu_pkg::DPU_BYTE_PAGE: main_ptr_nxt[dpu_pkg::PAGE_LSB +: dpu_pkg::BYTE_W] = sfr_wdata_i;
					dpu_pkg::DPU_BYTE_NONE: main_ptr_nxt = main_ptr;
				endcase
			end
		end
		else
		begin
			if (byte_wr)
				shadow_ptr_nxt = shadow_ptr;
			else if (ptr_load_i)
				shadow_ptr_nxt = ptr_load_val_i;
			else if (ptr_inc_i)
				shadow_ptr_nxt = shadow_ptr + dpu_pkg::PTR_ONE;
			else if (qual_move)
				shadow_ptr_nxt = shadow_step;
			if (byte_wr)
			begin
				unique case (wr_byte)
					dpu_pkg::DPU_BYTE_LOW: shadow_ptr_nxt[dpu_pkg::LOW_LSB +: dpu_pkg::BYTE_W] = sfr_wdata_i;
					dpu_pkg::DPU_BYTE_HIGH: shadow_ptr_nxt[dpu_pkg::HIGH_LSB +: dpu_pkg::BYTE_W] = sfr_wdata_i;
					dpu_pkg::DPU_BYTE_PAGE: shadow_ptr_nxt[dpu_pkg::PAGE_LSB +: dpu_pkg::BYTE_W] = sfr_wdata_i;
					dpu_pkg::DPU_BYTE_NONE: shadow_ptr_nxt = shadow_ptr;
				endcase
			end
		end
	end

	// The core's address comes from a flop, so it must track the next select and next pointers.
	// A plain copy of the selected pointer would lag one cycle behind every swap.
	always_comb
	begin
		logic sel_nxt;
		sel_nxt = pointer_select_r;
		if (ctrl_wr)
			sel_nxt = sfr_wdata_i[dpu_pkg::SEL_BIT];
		else if (qual_move && auto_toggle_enable_r)
			sel_nxt = !pointer_select_r;
		active_pointer_nxt = sel_nxt ? shadow_ptr_nxt : main_ptr_nxt;
	end

	// Registered copy of the active pointer.
	// Reset clears it together with both pointers, so the first read after reset is consistent.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			active_pointer_r <= dpu_pkg::PTR_RESET;
		else
			active_pointer_r <= active_pointer_nxt;
	end

	// Read data, one cycle after the strobe; only the selected pointer is visible.
	// A read in the same cycle as a write returns the value from before that write.
	always_comb
	begin
		if (sfr_addr_i == dpu_pkg::CTRL_ADDR)
			sfr_rdata_nxt = ctrl_value;
		else if (pointer_select_r)
			sfr_rdata_nxt = pick_byte(shadow_ptr, rd_byte);
		else
			sfr_rdata_nxt = pick_byte(main_ptr, rd_byte);
	end

	// Read answer and hit flag hold until the next read strobe.
	// Holding the answer lets a slow core take it at any later cycle.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			sfr_rdata_r <= dpu_pkg::READ_ZERO;
			sfr_hit_r <= 1'b0;
		end
		else if (sfr_rd_i)
		begin
			sfr_rdata_r <= sfr_rdata_nxt;
			sfr_hit_r <= (sfr_addr_i == dpu_pkg::CTRL_ADDR) || (rd_byte != dpu_pkg::DPU_BYTE_NONE);
		end
	end

	// Outputs straight from flops.
	// No output comes from combinational logic, so the core sees clean timing.
	assign sfr_rdata_o = sfr_rdata_r;
	assign sfr_hit_o = sfr_hit_r;
	assign active_pointer_o = active_pointer_r;
	assign pointer_select_o = pointer_select_r;

endmodule // dpu_top

//--- common/dpu_pkg.sv
// Constants and types shared by the dual data pointer unit.
package dpu_pkg;

	// Pointer width and byte layout.
	localparam int PTR_W = 24;
	localparam int BYTE_W = 8;
	localparam int LOW_LSB = 0;
	localparam int HIGH_LSB = 8;
	localparam int PAGE_LSB = 16;

	// Register addresses on the core's special register bus.
	localparam logic [7:0] CTRL_ADDR = 8'hA7;
	localparam logic [7:0] PTR_LOW_ADDR = 8'hA4;
	localparam logic [7:0] PTR_HIGH_ADDR = 8'hA5;
	localparam logic [7:0] PTR_PAGE_ADDR = 8'hA6;

	// Field positions inside the pointer control register.
	localparam int SEL_BIT = 0;
	localparam int MAIN_MODE_LSB = 2;
	localparam int SHADOW_MODE_LSB = 4;
	localparam int TOGGLE_BIT = 6;

	// Reset values and the unit step.
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [23:0] PTR_RESET = 24'h000000;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [23:0] PTR_ONE = 24'h000001;

	// Automatic update chosen per pointer.
	typedef enum logic [1:0] {
		DPU_MODE_STD = 2'b00,
		DPU_MODE_INC = 2'b01,
		DPU_MODE_DEC = 2'b10,
		DPU_MODE_TGL = 2'b11
	} dpu_mode_t;

	// Addressing of a completed move instruction.
	typedef enum logic [1:0] {
		DPU_ADDR_PTR = 2'b00,
		DPU_ADDR_PC = 2'b01,
		DPU_ADDR_REG = 2'b10,
		DPU_ADDR_NONE = 2'b11
	} dpu_addr_t;

	// Which pointer byte an address names.
	typedef enum logic [1:0] {
		DPU_BYTE_LOW = 2'b00,
		DPU_BYTE_HIGH = 2'b01,
		DPU_BYTE_PAGE = 2'b10,
		DPU_BYTE_NONE = 2'b11
	} dpu_byte_t;

endpackage

//--- src/dpu_ptr_step.sv
// Next value of one pointer after a qualifying move, by its update mode.
module dpu_ptr_step
(
	// Current pointer and mode.
	input wire logic [dpu_pkg::PTR_W-1:0] ptr_i,
	input wire dpu_pkg::dpu_mode_t mode_i,
	// Stepped pointer.
	output logic [dpu_pkg::PTR_W-1:0] step_o
);

	// Increment and decrement wrap around the full 24 bits.
	always_comb
	begin
		unique case (mode_i)
			dpu_pkg::DPU_MODE_STD: step_o = ptr_i;
			dpu_pkg::DPU_MODE_INC: step_o = ptr_i + dpu_pkg::PTR_ONE;
			dpu_pkg::DPU_MODE_DEC: step_o = ptr_i - dpu_pkg::PTR_ONE;
			dpu_pkg::DPU_MODE_TGL: step_o = ptr_i ^ dpu_pkg::PTR_ONE;
		endcase
	end

endmodule // dpu_ptr_step

//--- src/dpu_ptr_reg.sv
// One 24-bit pointer with byte writes, loads, increments and auto steps.
module dpu_ptr_reg
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Byte write from the register bus.
	input wire logic wr_en_i,
	input wire dpu_pkg::dpu_byte_t wr_byte_i,
	input wire logic [dpu_pkg::BYTE_W-1:0] wr_data_i,
	// Instruction operations.
	input wire logic load_en_i,
	input wire logic [dpu_pkg::PTR_W-1:0] load_val_i,
	input wire logic inc_en_i,
	input wire logic step_en_i,
	input wire logic [dpu_pkg::PTR_W-1:0] step_val_i,
	// Stored pointer.
	output logic [dpu_pkg::PTR_W-1:0] ptr_o
);

	logic [dpu_pkg::PTR_W-1:0] ptr_r;

	// A bus write beats a load, which beats an increment, which beats an auto step.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			ptr_r <= dpu_pkg::PTR_RESET;
		else if (wr_en_i)
		begin
			unique case (wr_byte_i)
				dpu_pkg::DPU_BYTE_LOW: ptr_r[dpu_pkg::LOW_LSB +: dpu_pkg::BYTE_W] <= wr_data_i;
				dpu_pkg::DPU_BYTE_HIGH: ptr_r[dpu_pkg::HIGH_LSB +: dpu_pkg::BYTE_W] <= wr_data_i;
				dpu_pkg::DPU_BYTE_PAGE: ptr_r[dpu_pkg::PAGE_LSB +: dpu_pkg::BYTE_W] <= wr_data_i;
				dpu_pkg::DPU_BYTE_NONE: ptr_r <= ptr_r;
			endcase
		end
		else if (load_en_i)
			ptr_r <= load_val_i;
		else if (inc_en_i)
			ptr_r <= ptr_r + dpu_pkg::PTR_ONE;
		else if (step_en_i)
			ptr_r <= step_val_i;
	end

	assign ptr_o = ptr_r;

endmodule // dpu_ptr_reg

//--- tb/dpu_core_model.sv
// Core-side model that drives the register bus and instruction pulses.
module dpu_core_model
(
	// Clock.
	input wire logic clk_i,
	// Requests towards the unit.
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] wdata_o,
	output logic load_o,
	output logic [23:0] load_val_o,
	output logic inc_o,
	output logic move_o,
	output dpu_pkg::dpu_addr_t move_addr_o,
	// Read answer.
	input wire logic [7:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// Lines start at zero with move addressing none; after a request idle data lines show inverted values so stale data never looks live.
	initial
	begin
		{addr_o, wr_o, rd_o, wdata_o, load_o, load_val_o, inc_o, move_o} = '0;
		move_addr_o = dpu_pkg::DPU_ADDR_NONE;
	end

	// Each request is one cycle, set and dropped at falling edges.
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(negedge clk_i);
		{addr_o, wdata_o, wr_o, rd_o} = {a, d, w, !w};
		@(negedge clk_i);
		{addr_o, wdata_o, wr_o, rd_o} = {~a, ~d, 2'b00};
		q = rdata_i;
	endtask

	// Instruction pulses on the active pointer.
	task automatic op(input logic ld, input logic [23:0] v, input logic inc, input logic mv,
		input dpu_pkg::dpu_addr_t ma);
		@(negedge clk_i);
		{load_o, load_val_o, inc_o, move_o} = {ld, v, inc, mv};
		move_addr_o = ma;
		@(negedge clk_i);
		{load_o, load_val_o, inc_o, move_o} = {1'b0, ~v, 2'b00};
		move_addr_o = dpu_pkg::DPU_ADDR_NONE;
	endtask
endmodule // dpu_core_model

//--- tb/dpu_top_asserts.sv
// Concurrent checks on the ports of the dual data pointer unit.
module dpu_top_asserts
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register bus.
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic sfr_hit_o,
	// Instruction operations and pointer state.
	input wire logic ptr_load_i,
	input wire logic [dpu_pkg::PTR_W-1:0] ptr_load_val_i,
	input wire logic ptr_inc_i,
	input wire logic move_done_i,
	input wire dpu_pkg::dpu_addr_t move_addr_i,
	input wire logic [dpu_pkg::PTR_W-1:0] active_pointer_o,
	input wire logic pointer_select_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:2] ctrl_r;
	logic [1:0] mode;
	logic quiet;
	logic qmove;

	// Mode fields change only by bus writes, so a bus-side copy suffices.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			ctrl_r <= 5'h00;
		else if (sfr_wr_i && sfr_addr_i == dpu_pkg::CTRL_ADDR)
			ctrl_r <= sfr_wdata_i[6:2];
	end

	// A move is judged alone only when no write, load or increment competes.
	assign quiet = !sfr_wr_i && !ptr_load_i && !ptr_inc_i;
	assign qmove = quiet && move_done_i && move_addr_i == dpu_pkg::DPU_ADDR_PTR;
	assign mode = pointer_select_o ? ctrl_r[5:4] : ctrl_r[3:2];

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	swap_on_move_a: assert property (qmove && ctrl_r[6] |=> pointer_select_o != $past(pointer_select_o))
		else $error("select kept after move");
	hold_select_a: assert property (quiet && !(qmove && ctrl_r[6]) |=> $stable(pointer_select_o))
		else $error("select changed");
	step_inc_a: assert property (qmove && !ctrl_r[6] && mode == 2'b01
		|=> active_pointer_o == $past(active_pointer_o) + 24'h000001) else $error("no post-increment");
	step_dec_a: assert property (qmove && !ctrl_r[6] && mode == 2'b10
		|=> active_pointer_o == $past(active_pointer_o) - 24'h000001) else $error("no post-decrement");
	step_tgl_a: assert property (qmove && !ctrl_r[6] && mode == 2'b11
		|=> active_pointer_o == ($past(active_pointer_o) ^ 24'h000001)) else $error("no low-bit toggle");
	pointer_still_a: assert property (quiet && !(qmove && (ctrl_r[6] || mode != 2'b00))
		|=> $stable(active_pointer_o)) else $error("pointer moved");
	load_active_a: assert property (ptr_load_i && !sfr_wr_i && !move_done_i
		|=> active_pointer_o == $past(ptr_load_val_i)) else $error("load missed");
	ctrl_read_a: assert property (sfr_rd_i && sfr_addr_i == dpu_pkg::CTRL_ADDR
		|=> sfr_hit_o && sfr_rdata_o[7] == 1'b0 && sfr_rdata_o[1] == 1'b0) else $error("bad control read");

	cover property (qmove && ctrl_r[6]);
	cover property (qmove && mode == 2'b10);
	cover property (ptr_inc_i && pointer_select_o);
endmodule // dpu_top_asserts

bind dpu_top dpu_top_asserts u_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
	.sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
	.sfr_hit_o(sfr_hit_o), .ptr_load_i(ptr_load_i), .ptr_load_val_i(ptr_load_val_i), .ptr_inc_i(ptr_inc_i),
	.move_done_i(move_done_i), .move_addr_i(move_addr_i), .active_pointer_o(active_pointer_o),
	.pointer_select_o(pointer_select_o));

//--- tb/testbench.sv
// Self-checking bench for the dual data pointer unit.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i;
	logic rst_n_i;
	logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, d;
	logic sfr_wr_i, sfr_rd_i, sfr_hit_o, ptr_load_i, ptr_inc_i, move_done_i, pointer_select_o;
	logic [23:0] ptr_load_val_i, active_pointer_o;
	dpu_pkg::dpu_addr_t move_addr_i;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;

	dpu_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
		.sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
		.ptr_load_i(ptr_load_i), .ptr_load_val_i(ptr_load_val_i), .ptr_inc_i(ptr_inc_i),
		.move_done_i(move_done_i), .move_addr_i(move_addr_i), .active_pointer_o(active_pointer_o),
		.pointer_select_o(pointer_select_o));
	dpu_core_model core (.clk_i(clk_i), .addr_o(sfr_addr_i), .wr_o(sfr_wr_i), .rd_o(sfr_rd_i),
		.wdata_o(sfr_wdata_i), .load_o(ptr_load_i), .load_val_o(ptr_load_val_i), .inc_o(ptr_inc_i),
		.move_o(move_done_i), .move_addr_o(move_addr_i), .rdata_i(sfr_rdata_o));

	// Free-running clock, 10 ns period.
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// The whole run needs about 120 cycles; a hang is cut off well beyond that.
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			conclude();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Expected pointer after one qualifying move in a given mode.
	function automatic logic [23:0] stepped(input logic [23:0] v, input logic [1:0] m);
		return m == 2'b01 ? v + 24'h1 : m == 2'b10 ? v - 24'h1 : m == 2'b11 ? v ^ 24'h1 : v;
	endfunction

	initial
	begin
		logic [1:0] md;
		logic [23:0] exp_ptr;
		rst_n_i = 1'b0;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		rst_n_i = 1'b1;
		core.bus(0, 8'hA7, 8'h00, d);
		chk("ctrl reset", 32'h00010000, {7'h0, sfr_hit_o, active_pointer_o[23:16], d});
		core.bus(1, 8'hFF, 8'h00, d);
		chk("reserved write", 32'h0, {7'h0, pointer_select_o, active_pointer_o});
		core.bus(0, 8'hFF, 8'h00, d);
		chk("unmapped read", 32'h0, {23'h0, sfr_hit_o, d});
		core.bus(1, 8'hA7, 8'hFF, d);
		core.bus(0, 8'hA7, 8'h00, d);
		chk("ctrl readback", 32'h7D, {24'h0, d});
		$display("test registers done");
		core.bus(1, 8'hA7, 8'h00, d);
		core.op(1, 24'h332211, 0, 0, dpu_pkg::DPU_ADDR_NONE);
		core.bus(1, 8'hA7, 8'h01, d);
		core.bus(1, 8'hA4, 8'h44, d);
		core.op(0, 24'h0, 1, 0, dpu_pkg::DPU_ADDR_NONE);
		core.bus(0, 8'hA4, 8'h00, d);
		chk("shadow low", 32'h45, {24'h0, d});
		core.bus(1, 8'hA7, 8'h00, d);
		core.bus(0, 8'hA6, 8'h00, d);
		chk("main page", 32'h33, {24'h0, d});
		chk("main pointer", 32'h332211, {8'h0, active_pointer_o});
		$display("test mapping done");
		for (int i = 0; i < 8; i++)
		begin
			md = 2'(i);
			core.bus(1, 8'hA7, i > 3 ? {2'b00, md, 4'h1} : {4'h0, md, 2'b00}, d);
			core.op(1, 24'h010000, 0, 0, dpu_pkg::DPU_ADDR_PTR);
			exp_ptr = stepped(24'h010000, md);
			core.op(0, 24'h0, 0, 1, dpu_pkg::DPU_ADDR_PTR);
			chk("mode step once", {8'h0, exp_ptr}, {8'h0, active_pointer_o});
			core.op(0, 24'h0, 0, 1, dpu_pkg::DPU_ADDR_PTR);
			chk("mode step twice", {8'h0, stepped(exp_ptr, md)}, {8'h0, active_pointer_o});
		end
		core.bus(1, 8'hA7, 8'h65, d);
		for (int i = 1; i < 4; i++)
			core.op(0, 24'h0, 0, 1, dpu_pkg::dpu_addr_t'(i));
		chk("other moves", 32'h01010000, {7'h0, pointer_select_o, active_pointer_o});
		$display("test modes done");
		core.bus(1, 8'hA7, 8'h54, d);
		core.op(1, 24'h0, 0, 0, dpu_pkg::DPU_ADDR_NONE);
		core.bus(1, 8'hA7, 8'h55, d);
		core.op(1, 24'h00D000, 0, 0, dpu_pkg::DPU_ADDR_NONE);
		core.op(0, 24'h0, 0, 1, dpu_pkg::DPU_ADDR_PTR);
		chk("swap to main", 32'h0, {7'h0, pointer_select_o, active_pointer_o});
		core.op(0, 24'h0, 0, 1, dpu_pkg::DPU_ADDR_PTR);
		chk("swap to shadow", 32'h0100D001, {7'h0, pointer_select_o, active_pointer_o});
		core.bus(1, 8'hA7, 8'h01, d);
		core.bus(0, 8'hA7, 8'h00, d);
		core.bus(1, 8'hA7, d + 8'h01, d);
		core.bus(0, 8'hA7, 8'h00, d);
		chk("ctrl increment", 32'h0, {pointer_select_o, 23'h0, d});
		$display("test toggle done");
		conclude();
	end
endmodule // testbench
